// *** core/osru_pkg.sv ***
package osru_pkg;
    // register byte addresses
    localparam logic [3:0] OSRU_ADDR_CTRL_STATUS = 4'h0;
    localparam logic [3:0] OSRU_ADDR_PIN_ENABLE = 4'h4;
    localparam logic [3:0] OSRU_ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] OSRU_ADDR_IRQ_MASK = 4'hc;
    // field positions in the control/status register, and the pin-select field in the pin-enable register
    localparam int OSRU_MODE_LSB = 0;
    localparam int OSRU_IRQ_EN_BIT = 8;
    localparam int OSRU_FLAG_LSB = 12;
    localparam int OSRU_PIN_SEL_LSB = 4;
    // reset values
    localparam logic [7:0] OSRU_MODE_RESET = 8'h00;
    localparam logic [3:0] OSRU_FLAG_RESET = 4'h0;
    localparam logic [3:0] OSRU_PIN_SEL_RESET = 4'h0;
    localparam logic [3:0] OSRU_MASK_RESET = 4'h0;
    // sampling timing
    localparam int OSRU_DIV_FAST = 8;
    localparam int OSRU_DIV_MID = 16;
    localparam int OSRU_DIV_SLOW = 128;
    localparam int OSRU_SAMPLES = 16;
    localparam int OSRU_PRESCALE_W = 7;
    // detection modes
    localparam logic [1:0] OSRU_MODE_EDGE = 2'h0;
    localparam logic [1:0] OSRU_MODE_DIV8 = 2'h1;
    localparam logic [1:0] OSRU_MODE_DIV16 = 2'h2;
    localparam logic [1:0] OSRU_MODE_DIV128 = 2'h3;

    typedef struct packed {
        logic [6:0] drive;
        logic [6:0] oe;
    } osru_motor_pins_type;
endpackage : osru_pkg

// *** core/osru_top.sv ***
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module osru_top
    import osru_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic i_clk_en,
    input wire logic [3:0] i_shared_pin_n,
    input wire logic [6:0] i_motor_drive,
    input wire logic [6:0] i_motor_oe,
    input wire logic [6:0] i_pin_is_port,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output osru_pkg::osru_motor_pins_type o_motor_pins,
    output logic o_shutdown_active,
    output logic o_irq
);
    import osru_pkg::*;

    // refuse sampling constants that the 5-bit run counter or the prescaler cannot serve
    if (OSRU_SAMPLES < 2 || OSRU_SAMPLES > 32 ||
        OSRU_DIV_SLOW > (1 << OSRU_PRESCALE_W)) begin : g_bad_cfg
        $error("osru_top: sampling constants out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] mode;
    logic irq_enable;
    logic [3:0] flag;
    logic [3:0] pin_select;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    wire [3:0] detect;

    ////////////////////////////////////////////////////////////////////////////
    // axi-lite write path: address and data latched in either order
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_bresp = 2'h0;
    wire wr_ctrl = do_write && (aw_addr == OSRU_ADDR_CTRL_STATUS);
    wire wr_pins = do_write && (aw_addr == OSRU_ADDR_PIN_ENABLE);
    wire wr_ista = do_write && (aw_addr == OSRU_ADDR_IRQ_STATUS);
    wire wr_mask = do_write && (aw_addr == OSRU_ADDR_IRQ_MASK);
    wire [3:0] wr_flags = w_data[OSRU_FLAG_LSB +: 4];

    // bresp is always okay; unmapped writes are dropped
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else if (i_clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[3:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi-lite read path, one cycle to rvalid
    logic [31:0] rd_word;
    wire [3:0] rd_addr = {s_axi_araddr[3:2], 2'h0};
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'h0;
    // reserved bits 11:9 read zero
    always_comb begin
        rd_word = 32'h0;
        case (rd_addr)
            OSRU_ADDR_CTRL_STATUS: rd_word = {16'h0, flag, 3'h0, irq_enable, mode};
            OSRU_ADDR_PIN_ENABLE: rd_word = {24'h0, pin_select, 4'h0};
            OSRU_ADDR_IRQ_STATUS: rd_word = {28'h0, irq_status};
            OSRU_ADDR_IRQ_MASK: rd_word = {28'h0, irq_mask};
            default: rd_word = 32'h0;
        endcase
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
        end else if (i_clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read-then-clear arming: a zero clears only a flag seen as one
    logic [3:0] flag_seen;
    wire rd_ctrl = s_axi_arvalid && s_axi_arready && (rd_addr == OSRU_ADDR_CTRL_STATUS);
    wire [3:0] flag_clear = (wr_ctrl && w_strb[1]) ? (flag_seen & ~wr_flags) : 4'h0;
    wire [3:0] next_flag = detect | (flag & ~flag_clear);

    // control register: reset clears it; writes load mode and irq enable, and a zero write clears a flag seen as one
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            mode <= OSRU_MODE_RESET;
            irq_enable <= 1'b0;
            flag <= OSRU_FLAG_RESET;
            flag_seen <= 4'h0;
            pin_select <= OSRU_PIN_SEL_RESET;
            irq_mask <= OSRU_MASK_RESET;
            irq_status <= 4'h0;
        end else if (i_clk_en) begin
            if (wr_ctrl && w_strb[0]) begin
                mode <= w_data[OSRU_MODE_LSB +: 8];
            end
            if (wr_ctrl && w_strb[1]) begin
                irq_enable <= w_data[OSRU_IRQ_EN_BIT];
            end
            flag <= next_flag;
            if (rd_ctrl) begin
                flag_seen <= flag;
            end else begin
                flag_seen <= flag_seen & ~flag_clear;
            end
            if (wr_pins && w_strb[0]) begin
                pin_select <= w_data[OSRU_PIN_SEL_LSB +: 4];
            end
            if (wr_mask && w_strb[0]) begin
                irq_mask <= w_data[3:0];
            end
            // set wins over write-one-to-clear
            irq_status <= detect | (irq_status & ~((wr_ista && w_strb[0]) ? w_data[3:0] : 4'h0));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared prescaler and sampling strobes
    logic [OSRU_PRESCALE_W-1:0] prescale;
    wire tick8 = (prescale[2:0] == 3'h7);
    wire tick16 = (prescale[3:0] == 4'hf);
    wire tick128 = (prescale == 7'h7f);

    // free-running, so strobe phase is independent of the request
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            prescale <= '0;
        end else if (i_clk_en) begin
            prescale <= prescale + 7'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-input synchroniser, edge and level detection
    // each input keeps its own state inside its generate scope, so every flop has one writer
    for (genvar g = 0; g < 4; g++) begin : g_req
        logic [2:0] sync;
        logic prev_level;
        logic [4:0] low_count;
        // unselected pin reads as idle high
        wire raw = pin_select[g] ? i_shared_pin_n[g] : 1'b1;
        wire [1:0] req_mode = mode[2*g +: 2];
        wire agreed = (sync[1] == sync[2]);
        wire level = agreed ? sync[2] : prev_level;
        wire strobe = (req_mode == OSRU_MODE_DIV8) ? tick8 :
                      (req_mode == OSRU_MODE_DIV16) ? tick16 :
                      (req_mode == OSRU_MODE_DIV128) ? tick128 : 1'b0;
        wire fell = prev_level && !level;
        wire edge_hit = (req_mode == OSRU_MODE_EDGE) && fell;
        wire lvl_hit = strobe && !level &&
                       (low_count == 5'(OSRU_SAMPLES - 1));
        // both paths feed the unregistered detect in the same cycle
        assign detect[g] = edge_hit || lvl_hit;

        always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
            if (I_RST) begin
                sync <= 3'h7;
                prev_level <= 1'b1;
                low_count <= 5'h0;
            end else if (i_clk_en) begin
                sync <= {sync[1:0], raw};
                prev_level <= level;
                if (req_mode == OSRU_MODE_EDGE) begin
                    low_count <= 5'h0;
                end else if (strobe) begin
                    if (level) begin
                        low_count <= 5'h0;
                    end else if (low_count == 5'(OSRU_SAMPLES - 1)) begin
                        low_count <= 5'h0;
                    end else begin
                        low_count <= low_count + 5'h1;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output shutdown: held exactly while any flag stands
    logic shutdown;
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            shutdown <= 1'b0;
        end else if (i_clk_en) begin
            shutdown <= |next_flag;
        end
    end

    // pins used as port or other-timer output keep their drive
    wire [6:0] force_off = shutdown ? ~i_pin_is_port : 7'h00;
    assign o_motor_pins.drive = i_motor_drive;
    assign o_motor_pins.oe = i_motor_oe & ~force_off;
    assign o_shutdown_active = shutdown;
    assign o_irq = (irq_enable && (|flag)) || (|(irq_status & irq_mask));
endmodule : osru_top

// *** dv/osru_req_src.sv ***
`timescale 1ns/100ps
// far-side request source: lines idle high as if pulled up
module osru_req_src (
    input wire logic i_clk,
    output logic [3:0] o_pin_n
);
    initial o_pin_n = 4'hf;
    // hold one line low for n cycles, then let it return high
    task automatic pull(input int idx, input int n);
        @(posedge i_clk);
        o_pin_n[idx] <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_pin_n[idx] <= 1'b1;
    endtask : pull
endmodule : osru_req_src

// *** dv/osru_checker.sv ***
`timescale 1ns/100ps
module osru_checker
    import osru_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic [6:0] i_motor_drive,
    input wire logic [6:0] i_motor_oe,
    input wire logic [6:0] i_pin_is_port,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire osru_pkg::osru_motor_pins_type o_motor_pins,
    input wire logic o_shutdown_active
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    // both write channels accepted at one edge
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    AST_OE_FORCE: assert property (o_motor_pins.oe ==
        (i_motor_oe & ~({7{o_shutdown_active}} & ~i_pin_is_port))) else $error("oe mismatch");
    AST_DRIVE_PASS: assert property (o_motor_pins.drive == i_motor_drive)
        else $error("drive altered");
    AST_RELEASE_BY_WRITE: assert property ($fell(o_shutdown_active) |-> $rose(s_axi_bvalid))
        else $error("shutdown left without a write");
    // both channels land in the holding flops first, the answer follows one edge later
    AST_B_LATENCY: assert property (s_wr_taken |-> ##2 s_axi_bvalid) else $error("no write answer");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    AST_B_OKAY: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0) else $error("bad bresp");
    AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
endmodule : osru_checker

bind osru_top osru_checker u_osru_checker (.I_CLK_SYS, .I_RST, .i_motor_drive, .i_motor_oe,
    .i_pin_is_port, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .o_motor_pins, .o_shutdown_active);

// *** dv/test_osru_top.sv ***
`timescale 1ns/100ps
module test_osru_top;
    import osru_pkg::*;
    logic I_CLK_SYS, I_RST, i_clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic o_shutdown_active, o_irq;
    logic [3:0] i_shared_pin_n, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [6:0] i_motor_drive, i_motor_oe, i_pin_is_port;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    osru_motor_pins_type o_motor_pins;
    int fails, compares, cyc, n;
    osru_top u_osru_top (.I_CLK_SYS, .I_RST, .i_clk_en, .i_shared_pin_n, .i_motor_drive,
        .i_motor_oe, .i_pin_is_port, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .o_motor_pins, .o_shutdown_active, .o_irq);
    osru_req_src u_osru_req_src (.i_clk(I_CLK_SYS), .o_pin_n(i_shared_pin_n));
    ////////////////////////////////////////////////////////////////////////////////
    // clock and a hang guard well above the longest run
    initial begin
        I_CLK_SYS = 1'b0;
        forever #10 I_CLK_SYS = ~I_CLK_SYS;
    end
    always @(posedge I_CLK_SYS) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // each channel held until its own ready, answers awaited with ready high
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge I_CLK_SYS);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin do @(posedge I_CLK_SYS); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
            begin do @(posedge I_CLK_SYS); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
        join
        do @(posedge I_CLK_SYS); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge I_CLK_SYS);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge I_CLK_SYS); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge I_CLK_SYS); while (!s_axi_rvalid);
        d = s_axi_rdata;
        chk(s_axi_rresp, 32'h0);
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task automatic wait_shut(input int lim);
        n = 0;
        while (o_shutdown_active !== 1'b1 && n < lim) begin
            @(posedge I_CLK_SYS);
            n++;
        end
    endtask : wait_shut
    // flag clear needs the flag seen as one first
    task automatic clr();
        axi_rd(OSRU_ADDR_CTRL_STATUS, rd);
        axi_wr(OSRU_ADDR_CTRL_STATUS, 32'h0, 4'hf);
        chk(o_shutdown_active, 0);
    endtask : clr
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        axi_rd(OSRU_ADDR_CTRL_STATUS, rd);
        chk(rd, 32'h0);
        axi_wr(OSRU_ADDR_PIN_ENABLE, 32'hf0, 4'hf);
        axi_rd(OSRU_ADDR_PIN_ENABLE, rd);
        chk(rd, 32'hf0);
    endtask : t_regs
    task automatic t_edge();
        u_osru_req_src.pull(0, 4);
        wait_shut(20);
        chk(o_shutdown_active, 1);
        chk(o_motor_pins.oe, i_motor_oe & i_pin_is_port);
        axi_rd(OSRU_ADDR_CTRL_STATUS, rd);
        chk(rd, 32'h1000);
        axi_wr(OSRU_ADDR_CTRL_STATUS, 32'hf000, 4'hf);
        axi_rd(OSRU_ADDR_CTRL_STATUS, rd);
        chk(rd, 32'h1000);
        clr();
    endtask : t_edge
    // a short low burst must be refused, a long one taken after sixteen strobes
    task automatic t_level(input int m, input int dv);
        axi_wr(OSRU_ADDR_CTRL_STATUS, 32'(m) << (2 * m), 4'hf);
        u_osru_req_src.pull(m, 8 * dv);
        repeat (10 * dv) @(posedge I_CLK_SYS);
        chk(o_shutdown_active, 0);
        fork
            u_osru_req_src.pull(m, 17 * dv + 12);
            wait_shut(17 * dv + 12);
        join
        chk(n >= 15 * dv && n <= 16 * dv + 12, 1);
        clr();
    endtask : t_level
    task automatic t_irq();
        chk(o_irq, 0);
        axi_wr(OSRU_ADDR_IRQ_MASK, 32'hf, 4'hf);
        chk(o_irq, 1);
        axi_wr(OSRU_ADDR_IRQ_STATUS, 32'hf, 4'hf);
        chk(o_irq, 0);
        axi_wr(OSRU_ADDR_IRQ_MASK, 32'h0, 4'hf);
        axi_wr(OSRU_ADDR_CTRL_STATUS, 32'h100, 4'hf);
        u_osru_req_src.pull(0, 4);
        wait_shut(20);
        chk(o_irq, 1);
    endtask : t_irq
    task automatic summarize();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    initial begin
        I_RST = 1'b1;
        i_clk_en = 1'b1;
        i_motor_drive = 7'h2a;
        i_motor_oe = 7'h7f;
        i_pin_is_port = 7'h05;
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (8) @(posedge I_CLK_SYS);
        I_RST <= 1'b0;
        t_regs();
        t_edge();
        t_level(1, OSRU_DIV_FAST);
        t_level(2, OSRU_DIV_MID);
        t_level(3, OSRU_DIV_SLOW);
        t_irq();
        summarize();
    end
endmodule : test_osru_top
